// ---- rtl/tpc_pkg.sv ----
package tpc_pkg;

  // ****************************************************************
  // Widths of the register port and of the counter.
  // ****************************************************************
  localparam int TPC_AW     = 8;
  localparam int TPC_DW     = 32;
  localparam int TPC_CW     = 16;
  localparam int TPC_CTRL_W = 4;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [TPC_AW-1:0] TPC_OFS_CTRL = 8'h00;
  localparam logic [TPC_AW-1:0] TPC_OFS_GRA  = 8'h04;
  localparam logic [TPC_AW-1:0] TPC_OFS_STAT = 8'h08;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int TPC_BIT_CAPT_MODE = 3;  // Capture when set, compare when clear.
  localparam int TPC_BIT_INIT      = 2;  // Initial pin level in compare mode.
  localparam int TPC_BIT_BOTH      = 1;  // Both edges in capture mode.
  localparam int TPC_STAT_CAPT     = 0;  // Sticky capture flag, write 1 to clear.
  localparam int TPC_STAT_MATCH    = 1;  // Sticky match flag, write 1 to clear.
  localparam int TPC_STAT_PIN      = 2;  // Present pin output level.
  localparam int TPC_STAT_OE_N     = 3;  // Present pin output enable, low drives.
  localparam int TPC_STAT_LEVEL    = 4;  // Synchronised pin input level.

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [TPC_CTRL_W-1:0] TPC_CTRL_RST = 4'h0;
  localparam logic [TPC_CW-1:0]     TPC_GRA_RST  = 16'h0000;
  localparam logic                  TPC_PIN_RST  = 1'b0;
  localparam logic                  TPC_OE_N_RST = 1'b0;

  // ****************************************************************
  // Pin action on compare match, coded as the low two control bits.
  // ****************************************************************
  typedef enum logic [1:0] {
    TPC_ACT_HOLD   = 2'b00,
    TPC_ACT_LOW    = 2'b01,
    TPC_ACT_HIGH   = 2'b10,
    TPC_ACT_TOGGLE = 2'b11
  } tpc_act_t;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic [TPC_AW-1:0] addr;
    logic [TPC_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } tpc_bus_req_t;

  typedef struct packed {
    logic [TPC_CW-1:0] value;
    logic              tick;
  } tpc_count_t;

endpackage

// ---- rtl/tpc_top.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// [RULE_01] Codes 0000 and 0100 hold the pin, which drives 0 from reset until control is written.
// [RULE_02] Compare low bits 01 start the pin at bit 2 and drive 0 on each match.
// [RULE_03] Compare low bits 10 start the pin at bit 2 and drive 1 on each match.
// [RULE_04] Compare low bits 11 start the pin at bit 2 and invert it on each match.
// [RULE_05] Bit 3 set makes register A capture with bit 2 ignored; low bits 00 take rising edges.
// [RULE_06] Capture low bits 01 capture only on falling edges.
// [RULE_07] Capture with bit 1 set captures on both edges whatever bit 0.
// [RULE_08] A chosen edge loads the counter into register A; compare checks it each count cycle.
module tpc_top
  import tpc_pkg::*;
(
  input  wire  logic              clock_i,
  input  wire  logic              rst_n_i,
  input  wire  logic              clk_en_i,
  input  wire  tpc_bus_req_t      bus_i,
  output logic [TPC_DW-1:0]       rdata_o,
  input  wire  tpc_count_t        count_i,
  input  wire  logic              ch4_pin_a_i,
  output logic                    ch4_pin_a_o,
  output logic                    ch4_pin_a_oe_n_o,
  output logic                    match_o,
  output logic                    capture_o
);

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [TPC_CTRL_W-1:0] io_control_reg;
  logic [TPC_CW-1:0]     general_reg_a_ch4;
  logic                  pin_sync1;
  logic                  pin_sync2;
  logic                  pin_prev;
  logic                  flag_capt;
  logic                  flag_match;

  logic [TPC_CTRL_W-1:0] next_io_control_reg;
  logic [TPC_CW-1:0]     next_general_reg_a_ch4;
  logic                  next_pin;
  logic                  next_oe_n;
  logic                  next_flag_capt;
  logic                  next_flag_match;
  logic [TPC_DW-1:0]     next_rdata;
  logic                  next_match;
  logic                  next_capture;

  // ****************************************************************
  // Decode.
  // ****************************************************************
  logic     wr_ctrl;
  logic     wr_gra;
  logic     wr_stat;
  logic     capt_mode;
  logic     rise;
  logic     fall;
  logic     edge_hit;
  logic     cmp_hit;
  tpc_act_t act;

  // Strobes are qualified here so that every consumer sees the same decode.
  assign wr_ctrl   = bus_i.wr && (bus_i.addr == TPC_OFS_CTRL);
  assign wr_gra    = bus_i.wr && (bus_i.addr == TPC_OFS_GRA);
  assign wr_stat   = bus_i.wr && (bus_i.addr == TPC_OFS_STAT);
  assign capt_mode = io_control_reg[TPC_BIT_CAPT_MODE];
  assign act       = tpc_act_t'(io_control_reg[1:0]);

  // Edges are seen only after the two synchroniser stages.
  assign rise = pin_sync2 && !pin_prev;
  assign fall = !pin_sync2 && pin_prev;

  // Edge choice in capture mode; bit 2 plays no part here.
  always_comb
  begin
    if (io_control_reg[TPC_BIT_BOTH])
    begin
      edge_hit = rise || fall;  // see [RULE_07]
    end
    else if (io_control_reg[0])
    begin
      edge_hit = fall;  // see [RULE_06]
    end
    else
    begin
      edge_hit = rise;  // see [RULE_05]
    end
  end

  // A match is checked only on a count cycle, so a stalled counter fires once.
  assign cmp_hit = !capt_mode && count_i.tick
                   && (count_i.value == general_reg_a_ch4);  // see [RULE_08]

  // ****************************************************************
  // Pin synchroniser; the first stage feeds the second stage only.
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_prev  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pin_sync1 <= ch4_pin_a_i;
      pin_sync2 <= pin_sync1;
      pin_prev  <= pin_sync2;
    end
  end

  // ****************************************************************
  // Control register and pin driver.
  // ****************************************************************
  // A control write wins over a match in the same cycle and, for compare codes with low bits
  // other than 00, sets the initial level, so software always sees its own level take effect.
  always_comb
  begin
    next_io_control_reg = io_control_reg;
    next_pin            = ch4_pin_a_o;
    next_oe_n           = ch4_pin_a_oe_n_o;
    if (wr_ctrl)
    begin
      next_io_control_reg = bus_i.wdata[TPC_CTRL_W-1:0];
      next_oe_n           = bus_i.wdata[TPC_BIT_CAPT_MODE];
      if (!bus_i.wdata[TPC_BIT_CAPT_MODE] && (bus_i.wdata[1:0] != 2'b00))
      begin
        next_pin = bus_i.wdata[TPC_BIT_INIT];  // see [RULE_02]
      end
    end
    else if (cmp_hit)
    begin
      unique case (act)
        TPC_ACT_HOLD:   next_pin = ch4_pin_a_o;   // see [RULE_01]
        TPC_ACT_LOW:    next_pin = 1'b0;          // see [RULE_02]
        TPC_ACT_HIGH:   next_pin = 1'b1;          // see [RULE_03]
        TPC_ACT_TOGGLE: next_pin = !ch4_pin_a_o;  // see [RULE_04]
      endcase
    end
  end

  // Reset drives 0 with the driver on until the first control write.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      io_control_reg   <= TPC_CTRL_RST;
      ch4_pin_a_o      <= TPC_PIN_RST;   // see [RULE_01]
      ch4_pin_a_oe_n_o <= TPC_OE_N_RST;
    end
    else if (clk_en_i)
    begin
      io_control_reg   <= next_io_control_reg;
      ch4_pin_a_o      <= next_pin;
      ch4_pin_a_oe_n_o <= next_oe_n;
    end
  end

  // ****************************************************************
  // Register A, events and sticky flags.
  // ****************************************************************
  // A capture beats a software write to register A in the same cycle,
  // because the captured count would otherwise be lost for good.
  always_comb
  begin
    next_general_reg_a_ch4 = general_reg_a_ch4;
    next_capture           = capt_mode && edge_hit;
    next_match             = cmp_hit;
    if (capt_mode && edge_hit)
    begin
      next_general_reg_a_ch4 = count_i.value;  // see [RULE_08]
    end
    else if (wr_gra)
    begin
      next_general_reg_a_ch4 = bus_i.wdata[TPC_CW-1:0];
    end
    next_flag_capt  = flag_capt;
    next_flag_match = flag_match;
    if (wr_stat && bus_i.wdata[TPC_STAT_CAPT])
    begin
      next_flag_capt = 1'b0;
    end
    if (wr_stat && bus_i.wdata[TPC_STAT_MATCH])
    begin
      next_flag_match = 1'b0;
    end
    // Setting comes last so that an event in the clearing cycle survives.
    if (next_capture)
    begin
      next_flag_capt = 1'b1;
    end
    if (next_match)
    begin
      next_flag_match = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      general_reg_a_ch4 <= TPC_GRA_RST;
      capture_o         <= 1'b0;
      match_o           <= 1'b0;
      flag_capt         <= 1'b0;
      flag_match        <= 1'b0;
    end
    else if (clk_en_i)
    begin
      general_reg_a_ch4 <= next_general_reg_a_ch4;
      capture_o         <= next_capture;
      match_o           <= next_match;
      flag_capt         <= next_flag_capt;
      flag_match        <= next_flag_match;
    end
  end

  // ****************************************************************
  // Read port; unmapped offsets read as zero.
  // ****************************************************************
  always_comb
  begin
    next_rdata = '0;
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        TPC_OFS_CTRL: next_rdata[TPC_CTRL_W-1:0] = io_control_reg;
        TPC_OFS_GRA:  next_rdata[TPC_CW-1:0]     = general_reg_a_ch4;
        TPC_OFS_STAT:
        begin
          next_rdata[TPC_STAT_CAPT]  = flag_capt;
          next_rdata[TPC_STAT_MATCH] = flag_match;
          next_rdata[TPC_STAT_PIN]   = ch4_pin_a_o;
          next_rdata[TPC_STAT_OE_N]  = ch4_pin_a_oe_n_o;
          next_rdata[TPC_STAT_LEVEL] = pin_sync2;
        end
        default:      next_rdata = '0;
      endcase
    end
  end

  // Read data stand for one cycle only and drop back to zero after.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= '0;
    end
    else if (clk_en_i)
    begin
      rdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_cmp_step(logic [1:0] code);
    clk_en_i && !capt_mode && (io_control_reg[1:0] == code) && cmp_hit && !wr_ctrl;
  endsequence

  sequence s_capt_step;
    clk_en_i && capt_mode && !wr_ctrl;
  endsequence

  property p_hold_level;
    clk_en_i && !capt_mode && (act == TPC_ACT_HOLD) && !wr_ctrl
      |=> (ch4_pin_a_o == $past(ch4_pin_a_o)) && !ch4_pin_a_oe_n_o;
  endproperty
  a_hold_level: assert property (p_hold_level)  // see [RULE_01]
    else $error("Pin moved in a hold mode.");

  property p_init_level;
    clk_en_i && wr_ctrl && !bus_i.wdata[TPC_BIT_CAPT_MODE] && (bus_i.wdata[1:0] != 2'b00)
      |=> ch4_pin_a_o == $past(bus_i.wdata[TPC_BIT_INIT]);
  endproperty
  a_init_level: assert property (p_init_level)  // see [RULE_02]
    else $error("Initial level not taken from bit 2.");

  property p_match_low;
    s_cmp_step(2'b01) |=> !ch4_pin_a_o ##0 match_o;
  endproperty
  a_match_low: assert property (p_match_low)  // see [RULE_02]
    else $error("Pin not driven low on match.");

  property p_match_high;
    s_cmp_step(2'b10) |=> ch4_pin_a_o;
  endproperty
  a_match_high: assert property (p_match_high)  // see [RULE_03]
    else $error("Pin not driven high on match.");

  property p_match_toggle;
    s_cmp_step(2'b11) |=> ch4_pin_a_o != $past(ch4_pin_a_o);
  endproperty
  a_match_toggle: assert property (p_match_toggle)  // see [RULE_04]
    else $error("Pin not inverted on match.");

  property p_capt_rise;
    s_capt_step ##0 (io_control_reg[1:0] == 2'b00) ##0 rise
      |=> capture_o && (general_reg_a_ch4 == $past(count_i.value)) && ch4_pin_a_oe_n_o;
  endproperty
  a_capt_rise: assert property (p_capt_rise)  // see [RULE_05]
    else $error("Rising edge not captured.");

  property p_capt_fall_only;
    s_capt_step ##0 (io_control_reg[1:0] == 2'b01) ##0 rise |=> !capture_o;
  endproperty
  a_capt_fall_only: assert property (p_capt_fall_only)  // see [RULE_06]
    else $error("Capture on a rising edge in falling mode.");

  property p_capt_both;
    s_capt_step ##0 io_control_reg[TPC_BIT_BOTH] ##0 (rise || fall) |=> capture_o;
  endproperty
  a_capt_both: assert property (p_capt_both)  // see [RULE_07]
    else $error("Edge missed in both-edge mode.");

  property p_compare;
    clk_en_i && !capt_mode && count_i.tick && (count_i.value == general_reg_a_ch4)
      |=> match_o;
  endproperty
  a_compare: assert property (p_compare)  // see [RULE_08]
    else $error("Compare match not flagged.");

  property p_match_pulse;
    clk_en_i && match_o && !cmp_hit |=> !match_o;
  endproperty
  a_match_pulse: assert property (p_match_pulse)  // see [RULE_08]
    else $error("Match pulse longer than one cycle.");

endmodule

// ---- bench/tpc_pin_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Far-side model of the channel pin: a signal source that takes the
// wire whenever the block releases it.
// ****************************************************************
module tpc_pin_model
(
  input  wire logic pin_o_i,
  input  wire logic oe_n_i,
  input  wire logic level_i,
  output logic      pin_i_o
);
  // The wire shows the block's level while it drives and the source level otherwise.
  // The source is strong, so a released wire never floats here.
  assign pin_i_o = oe_n_i ? level_i : pin_o_i;
endmodule

// ---- bench/tb_timer_ch4a_pin_io_control.sv ----
`timescale 1ns/10ps
module tb_timer_ch4a_pin_io_control
  import tpc_pkg::*;
();
  logic              clock_i;
  logic              rst_n_i;
  logic              clk_en_i;
  tpc_bus_req_t      bus_i;
  logic [TPC_DW-1:0] rdata_o;
  tpc_count_t        count_i;
  logic              pin_in;
  logic              pin_out;
  logic              pin_oe_n;
  logic              match_o;
  logic              capture_o;
  logic              src_level;
  int                err_total;
  int                samples_checked;

  // ****************************************************************
  // Block and far-side pin source.
  // ****************************************************************
  tpc_top tpc_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .count_i(count_i), .ch4_pin_a_i(pin_in), .ch4_pin_a_o(pin_out),
    .ch4_pin_a_oe_n_o(pin_oe_n), .match_o(match_o), .capture_o(capture_o));
  tpc_pin_model tpc_pin_model_i (.pin_o_i(pin_out), .oe_n_i(pin_oe_n), .level_i(src_level),
    .pin_i_o(pin_in));

  // Free-running 50 ns clock.
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A write holds the strobe for exactly one cycle.
  task automatic wr_reg(input logic [TPC_AW-1:0] a, input logic [TPC_DW-1:0] d);
    @(posedge clock_i);
    bus_i.addr  <= a;
    bus_i.wdata <= d;
    bus_i.wr    <= 1'b1;
    @(posedge clock_i);
    bus_i.wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic chk_reg(input logic [TPC_AW-1:0] a, input logic [31:0] exp, input string what);
    @(posedge clock_i);
    bus_i.addr <= a;
    bus_i.rd   <= 1'b1;
    @(posedge clock_i);
    bus_i.rd   <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask

  // One count cycle; the match answer is settled when this returns.
  task automatic tick(input logic [TPC_CW-1:0] v);
    @(posedge clock_i);
    count_i <= '{value: v, tick: 1'b1};
    @(posedge clock_i);
    count_i.tick <= 1'b0;
    #1;
  endtask

  // Moves the source pin and counts capture pulses over a bounded window.
  task automatic edge_run(input logic lvl, input logic [TPC_CW-1:0] v, input logic want,
                          input logic [TPC_CW-1:0] old);
    logic [31:0] cnt;
    cnt = 0;
    @(posedge clock_i);
    count_i.value <= v;
    src_level     <= lvl;
    for (int n = 0; n < 8; n++)
    begin
      @(posedge clock_i);
      #1;
      cnt = cnt + capture_o;
    end
    chk("capture pulses", {31'h0, want}, cnt);
    chk_reg(TPC_OFS_GRA, {16'h0, want ? v : old}, "reg A after edge");
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic test_reset();
    chk("pin after reset", 32'h0, {31'h0, pin_out});
    chk("oe_n after reset", 32'h0, {31'h0, pin_oe_n});
    chk_reg(TPC_OFS_CTRL, 32'h0, "control after reset");
    chk_reg(8'h0c, 32'h0, "unmapped read");
    tick(16'h0000);
    chk("pin held after reset", 32'h0, {31'h0, pin_out});
    $display("test reset done");
  endtask

  // Every compare code: initial level, a near miss, a disabled hit, then a real match.
  task automatic test_compare();
    logic [3:0]  code;
    logic        exp_pin;
    logic [15:0] a;
    exp_pin = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      code = 4'(i);
      a = 16'h1230 + 16'(i);
      wr_reg(TPC_OFS_GRA, {16'h0, a});
      wr_reg(TPC_OFS_CTRL, {28'h0, code});
      if (code[1:0] != 2'b00)
        exp_pin = code[2];
      #1;
      chk("initial pin", 32'(exp_pin), 32'(pin_out));
      chk("oe_n compare", 32'h0, {31'h0, pin_oe_n});
      tick(a + 16'h0001);
      chk("match on other value", 32'h0, {31'h0, match_o});
      // The enable moves on a rising edge like every other input.
      @(posedge clock_i);
      clk_en_i <= 1'b0;
      tick(a);
      chk("match while disabled", 32'h0, {31'h0, match_o});
      @(posedge clock_i);
      clk_en_i <= 1'b1;
      tick(a);
      if (code[1:0] == 2'b11)
        exp_pin = ~exp_pin;
      else if (code[1:0] != 2'b00)
        exp_pin = code[1];
      chk("match pulse", 32'h1, {31'h0, match_o});
      chk("pin after match", 32'(exp_pin), 32'(pin_out));
      @(posedge clock_i);
      #1;
      chk("match one cycle", 32'h0, {31'h0, match_o});
      chk_reg(TPC_OFS_STAT, {27'h0, exp_pin, 1'b0, exp_pin, 2'b10}, "status");
      wr_reg(TPC_OFS_STAT, 32'h3);
      chk_reg(TPC_OFS_STAT, {27'h0, exp_pin, 1'b0, exp_pin, 2'b00}, "status cleared");
    end
    $display("test compare done");
  endtask

  // Every capture code, bit 2 both ways: a rising then a falling edge.
  task automatic test_capture();
    logic [3:0] code;
    logic       up;
    logic       dn;
    logic [15:0] prev;
    for (int i = 8; i < 16; i++)
    begin
      code = 4'(i);
      up = code[1] | ~code[0];
      dn = code[1] | code[0];
      src_level <= 1'b0;
      wr_reg(TPC_OFS_CTRL, {28'h0, code});
      // Switching the wire over may leave a stray edge, so let it drain first.
      repeat (6) @(posedge clock_i);
      #1;
      chk("oe_n capture", 32'h1, {31'h0, pin_oe_n});
      wr_reg(TPC_OFS_GRA, 32'h0);
      prev = up ? 16'h0a00 + 16'(i) : 16'h0000;
      edge_run(1'b1, 16'h0a00 + 16'(i), up, 16'h0000);
      edge_run(1'b0, 16'h0b00 + 16'(i), dn, prev);
      // Every capture code takes at least one of the two edges, so the flag is set here.
      chk_reg(TPC_OFS_STAT, 32'h0000_0009, "status capture");
      wr_reg(TPC_OFS_STAT, 32'h3);
    end
    $display("test capture done");
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    bus_i = '0;
    count_i = '0;
    src_level = 1'b0;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    test_reset();
    test_compare();
    test_capture();
    end_of_test();
  end
endmodule
